// *** eesm_eeprom_model.sv ***
// Purpose: Behavioural 128-word serial EEPROM at the far side
// Assumes: Bits sampled on clock rise; line resolved by the bench
// Notes: busy_i sets write time in 100 ns steps; starts locked
`timescale 1ns/1ps
module eesm_eeprom_model (
  input wire logic sel_i,
  input wire logic sck_i,
  input wire logic din_i,
  input wire logic [15:0] busy_i,
  output logic dout_o,
  output logic doe_o
);
  logic [7:0] mem [0:127]; // Word array
  logic [17:0] sh; // Incoming frame, MSB first
  logic [6:0] ra; // Read address
  logic [6:0] pa; // Pending write address
  logic [7:0] pd; // Pending write data
  logic locked, busy, status, pend, rd; // Model flags
  logic [11:0] hist; // Last three: 1 unlock 2 write 3 lock 4 read
  int nbit; // Bits taken since the start bit
  // Power-up state
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = {i[6:0], 1'b0} ^ 8'ha5;
    end
    {locked, busy, status, pend, rd} = 5'h10;
    {dout_o, doe_o} = 2'h0;
    hist = 12'h000;
    nbit = 0;
  end
  // Select; status mode shows ready
  always @(posedge sel_i) begin
    nbit = 0;
    rd = 1'b0;
    if (status) begin
      doe_o = 1'b1;
      dout_o = !busy;
    end
  end
  // Ready when programming ends
  always @(negedge busy) if (sel_i && status) dout_o = 1'b1;
  // Deselect releases line, starts queued write
  always @(negedge sel_i) begin
    doe_o = 1'b0;
    dout_o = !dout_o;
    if (pend) begin
      pend = 1'b0;
      busy = 1'b1;
      status = 1'b1;
      fork
        begin
          #(busy_i * 100);
          mem[pa] = pd;
          busy = 1'b0;
        end
      join_none
    end else if (!busy) begin
      status = 1'b0;
    end
  end
  // Frame decoded as bits arrive
  always @(posedge sck_i) if (sel_i && (nbit > 0 || din_i === 1'b1)) begin
    sh = {sh[16:0], din_i};
    nbit++;
    if (nbit == 10 && sh[8:7] == 2'b10) begin
      rd = 1'b1;
      ra = sh[6:0];
      hist = {hist[7:0], 4'h4};
    end
    if (nbit == 10 && sh[8:5] == 4'b0011) begin
      locked = 1'b0;
      hist = {hist[7:0], 4'h1};
    end
    if (nbit == 10 && sh[8:5] == 4'b0000) begin
      locked = 1'b1;
      hist = {hist[7:0], 4'h3};
    end
    // Writes are refused while locked
    if (nbit == 18 && sh[16:15] == 2'b01) begin
      hist = {hist[7:0], 4'h2};
      if (!locked) begin
        pend = 1'b1;
        pa = sh[14:8];
        pd = sh[7:0];
      end
    end
    // Read data shifted out after each rise
    if (rd && nbit >= 11 && nbit <= 18) begin
      #60;
      doe_o = 1'b1;
      dout_o = mem[ra][18-nbit];
    end
  end
endmodule : eesm_eeprom_model

// *** eesm_frame.sv ***
// Purpose: Bit engine that clocks one framed command or a busy poll
// Assumes: Runs on the memory clock; din_i already synchronised
// Notes: Select, serial clock and data all come from flops here
`timescale 1ns/1ps
module eesm_frame (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic poll_i,
  input wire logic [eesm_pkg::FRAME_W-1:0] tx_i,
  input wire logic [4:0] tx_len_i,
  input wire logic [3:0] rx_len_i,
  input wire logic din_i,
  output logic done_o,
  output logic [eesm_pkg::DATA_W-1:0] rx_o,
  output logic sel_o,
  output logic sck_o,
  output logic dout_o,
  output logic doe_o
);
  // Engine states, Gray along the bit loop
  typedef enum logic [2:0] {
    E_IDLE = 3'h0, E_LOW = 3'h1, E_HIGH = 3'h3, E_END = 3'h2, E_POLL = 3'h6
  } eesm_estate_t;

  typedef struct packed {
    eesm_estate_t st;
    logic [4:0] cnt; // Phase counter
    logic [4:0] idx; // Bit number in frame
    logic [4:0] tot; // Bits in frame
    logic [4:0] txl; // Bits driven
    logic [eesm_pkg::FRAME_W-1:0] sh; // Outgoing bits, MSB first
    logic [eesm_pkg::DATA_W-1:0] rx; // Incoming bits
    logic sel;
    logic sck;
    logic dout;
    logic oe;
    logic done;
  } eesm_eng_t;

  eesm_eng_t q, n;

  // Next-state logic
  always_comb begin
    n = q;
    n.done = 1'b0;
    unique case (q.st)
      E_IDLE: begin
        if (start_i) begin
          n.sel = 1'b1;
          n.sck = 1'b0;
          n.cnt = '0;
          n.idx = '0;
          n.sh = tx_i;
          n.txl = tx_len_i;
          n.tot = tx_len_i + 5'(rx_len_i);
          n.rx = '0;
          if (poll_i) begin
            n.oe = 1'b0; // Line left to the memory
            n.st = E_POLL;
          end else begin
            n.oe = (tx_len_i != 5'h00);
            n.dout = tx_i[eesm_pkg::FRAME_W-1];
            n.st = E_LOW;
          end
        end
      end
      E_LOW: begin
        n.cnt = q.cnt + 5'h01;
        if (q.cnt == eesm_pkg::LOW_CYC - 5'h01) begin
          n.cnt = '0;
          n.sck = 1'b1;
          n.st = E_HIGH;
        end
      end
      E_HIGH: begin
        n.cnt = q.cnt + 5'h01;
        if (q.cnt == eesm_pkg::HIGH_CYC - 5'h01) begin
          n.cnt = '0;
          n.sck = 1'b0;
          n.idx = q.idx + 5'h01;
          n.sh = {q.sh[eesm_pkg::FRAME_W-2:0], 1'b0};
          // Read bits taken late in the high phase
          if (q.idx >= q.txl) begin
            n.rx = {q.rx[eesm_pkg::DATA_W-2:0], din_i};
          end
          if (q.idx + 5'h01 >= q.tot) begin
            n.oe = 1'b0;
            n.sel = 1'b0;
            n.st = E_END;
          end else begin
            if (q.idx + 5'h01 < q.txl) begin
              n.dout = q.sh[eesm_pkg::FRAME_W-2];
            end else begin
              n.oe = 1'b0; // Release for read data
            end
            n.st = E_LOW;
          end
        end
      end
      E_POLL: begin
        // Wait select lead, then for the line to go high
        if (q.cnt != eesm_pkg::POLL_LEAD) begin
          n.cnt = q.cnt + 5'h01;
        end else if (din_i) begin
          n.cnt = '0;
          n.sel = 1'b0;
          n.st = E_END;
        end
      end
      E_END: begin
        // Deselect dwell before the next frame
        n.cnt = q.cnt + 5'h01;
        if (q.cnt == eesm_pkg::LOW_CYC - 5'h01) begin
          n.cnt = '0;
          n.done = 1'b1;
          n.st = E_IDLE;
        end
      end
      default: n.st = E_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign done_o = q.done;
  assign rx_o = q.rx;
  assign sel_o = q.sel;
  assign sck_o = q.sck;
  assign dout_o = q.dout;
  assign doe_o = q.oe;
endmodule : eesm_frame

// *** eesm_pkg.sv ***
// Purpose: Shared constants, types and helpers of the serial EEPROM master
// Assumes: Memory clock drives the link-side logic; 7-bit word address, 8-bit words
// Notes: Serial timing is counted in memory-clock cycles (unit mclk)
package eesm_pkg;
  // Memory organisation
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int WORDS = 128;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 7'(WORDS - 1);

  // Serial timing minima, in memory-clock cycles
  localparam int SCK_PERIOD_MIN_MCLK = 50;
  localparam int SCK_HIGH_MIN_MCLK = 24;
  localparam int SCK_LOW_MIN_MCLK = 24;
  localparam int SEL_SETUP_MIN_MCLK = 15;
  localparam int DATA_SETUP_MIN_MCLK = 15;
  localparam int DATA_HOLD_MIN_MCLK = 15;
  // Memory clock period, used only to keep the bit rate below the limit
  localparam int MEM_CLK_PERIOD_NS = 30;
  localparam int MAX_RATE_KHZ = 1000;

  // Larger of two figures
  function automatic int eesm_max(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : eesm_max

  // High phase also carries data hold; low phase carries setup and select lead
  localparam int HIGH_MCLK = eesm_max(eesm_max(SCK_HIGH_MIN_MCLK, DATA_HOLD_MIN_MCLK),
                                      (SCK_PERIOD_MIN_MCLK + 1) / 2);
  localparam int LOW_MCLK = eesm_max(eesm_max(SCK_LOW_MIN_MCLK, DATA_SETUP_MIN_MCLK),
    eesm_max(SEL_SETUP_MIN_MCLK, SCK_PERIOD_MIN_MCLK - HIGH_MCLK));
  // Resulting bit rate in kHz, must stay below MAX_RATE_KHZ
  localparam int RATE_KHZ = 1000000 / ((HIGH_MCLK + LOW_MCLK) * MEM_CLK_PERIOD_NS);
  localparam logic [4:0] HIGH_CYC = 5'(HIGH_MCLK);
  localparam logic [4:0] LOW_CYC = 5'(LOW_MCLK);
  localparam logic [4:0] POLL_LEAD = 5'(SEL_SETUP_MIN_MCLK);

  // Command framing: start bit, opcode, address, optional data
  localparam int FRAME_W = 18;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [ADDR_W-1:0] EXT_UNLOCK = 7'h60;
  localparam logic [ADDR_W-1:0] EXT_LOCK = 7'h00;
  localparam logic [4:0] LEN_CMD = 5'h0a;
  localparam logic [4:0] LEN_WRITE = 5'h12;
  localparam logic [3:0] RX_NONE = 4'h0;
  localparam logic [3:0] RX_BYTE = 4'h8;

  // User request carried to the link side
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } eesm_req_t;

  // Result carried back to the system side
  typedef struct packed {
    logic boot;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } eesm_rsp_t;

  // Build a left-aligned frame
  function automatic logic [FRAME_W-1:0] eesm_frame_f(input logic [1:0] op,
      input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
    return {1'b1, op, addr, data};
  endfunction : eesm_frame_f
endpackage : eesm_pkg

// *** eesm_sync.sv ***
// Purpose: Two-flop level synchroniser
// Assumes: Input is a level or toggle from another clock domain or a pin
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module eesm_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_q; // First stage, read only by q_o

  // Two-stage capture
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule : eesm_sync

// *** eesm_top.sv ***
// Purpose: Serial EEPROM master with power-on read and locked user writes
// Assumes: sys_clk_i for users, mem_clk_i is the memory clock of the link
// Notes: One request outstanding; boot read of all words precedes any request
`timescale 1ns/1ps
module eesm_top (
  input wire logic sys_clk_i,
  input wire logic mem_clk_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [eesm_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [eesm_pkg::DATA_W-1:0] req_wdata_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic rsp_write_o,
  output logic [eesm_pkg::ADDR_W-1:0] rsp_addr_o,
  output logic [eesm_pkg::DATA_W-1:0] rsp_data_o,
  output logic boot_valid_o,
  output logic boot_done_o,
  output logic eeprom_select_o,
  output logic eeprom_serial_clock_o,
  output logic eeprom_serial_data_o,
  output logic eeprom_serial_data_oe_o,
  input wire logic eeprom_serial_data_i
);
  // ---------------- Reset release per domain ----------------
  logic [1:0] sys_rst_q; // System-side release chain
  logic [1:0] mem_rst_q; // Link-side release chain
  logic sys_rst_n; // Released reset, system side
  logic mem_rst_n; // Released reset, link side

  // Asynchronous assert, two-flop release on the system clock
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sys_rst_q <= 2'h0;
    end else begin
      sys_rst_q <= {sys_rst_q[0], 1'b1};
    end
  end

  // Same on the memory clock
  always_ff @(posedge mem_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_rst_q <= 2'h0;
    end else begin
      mem_rst_q <= {mem_rst_q[0], 1'b1};
    end
  end

  assign sys_rst_n = sys_rst_q[1];
  assign mem_rst_n = mem_rst_q[1];

  // ---------------- System-side state ----------------
  typedef struct packed {
    eesm_pkg::eesm_req_t req; // Held request for the link side
    logic req_tgl; // Flips once per request
    logic rsp_seen; // Last result toggle consumed
    logic ack_tgl; // Echo of consumed results
    logic busy; // Request outstanding
    logic boot_done; // Power-on read finished
    logic ready;
    logic rsp_valid;
    logic boot_valid;
    logic rsp_write;
    logic [eesm_pkg::ADDR_W-1:0] rsp_addr;
    logic [eesm_pkg::DATA_W-1:0] rsp_data;
  } eesm_sys_t;

  // ---------------- Link-side state ----------------
  typedef enum logic [3:0] {
    M_BOOT = 4'h0, M_BOOT_WT = 4'h1, M_POST = 4'h3, M_IDLE = 4'h2,
    M_UNLOCK = 4'h6, M_WRITE = 4'h7, M_POLL = 4'h5, M_LOCK = 4'h4, M_READ = 4'hc
  } eesm_mstate_t;

  typedef struct packed {
    eesm_mstate_t st;
    logic req_seen; // Last request toggle taken
    eesm_pkg::eesm_req_t req; // Captured request
    eesm_pkg::eesm_rsp_t pend; // Result waiting to be posted
    eesm_pkg::eesm_rsp_t rsp; // Posted result, stable until echoed
    logic rsp_tgl; // Flips once per posted result
    logic [eesm_pkg::ADDR_W-1:0] boot_addr; // Power-on read pointer
    logic start; // Engine start pulse
    logic poll; // Engine poll mode
    logic [eesm_pkg::FRAME_W-1:0] tx;
    logic [4:0] tx_len;
    logic [3:0] rx_len;
  } eesm_mem_t;

  eesm_sys_t s_q, s_d;
  eesm_mem_t m_q, m_d;

  logic rsp_tgl_s; // Result toggle seen on system clock
  logic req_tgl_m; // Request toggle seen on memory clock
  logic ack_tgl_m; // Echo seen on memory clock
  logic din_m; // Data pin seen on memory clock
  logic eng_done; // Frame finished
  logic [eesm_pkg::DATA_W-1:0] eng_rx; // Bits read in last frame

  // Crossing of toggles and the data pin
  eesm_sync u_sync_rsp (
    .clk_i(sys_clk_i),
    .rst_n_i(sys_rst_n),
    .d_i(m_q.rsp_tgl),
    .q_o(rsp_tgl_s)
  );
  eesm_sync u_sync_req (
    .clk_i(mem_clk_i),
    .rst_n_i(mem_rst_n),
    .d_i(s_q.req_tgl),
    .q_o(req_tgl_m)
  );
  eesm_sync u_sync_ack (
    .clk_i(mem_clk_i),
    .rst_n_i(mem_rst_n),
    .d_i(s_q.ack_tgl),
    .q_o(ack_tgl_m)
  );
  eesm_sync u_sync_din (
    .clk_i(mem_clk_i),
    .rst_n_i(mem_rst_n),
    .d_i(eeprom_serial_data_i),
    .q_o(din_m)
  );

  // ---------------- System-side logic ----------------
  always_comb begin
    s_d = s_q;
    s_d.rsp_valid = 1'b0;
    s_d.boot_valid = 1'b0;
    // Accept a request while idle and after the power-on read
    if (req_valid_i && s_q.ready) begin
      s_d.req.write = req_write_i;
      s_d.req.addr = req_addr_i;
      s_d.req.wdata = req_wdata_i;
      s_d.req_tgl = ~s_q.req_tgl;
      s_d.busy = 1'b1;
    end
    // New result from the link side; fields are stable by now
    if (rsp_tgl_s != s_q.rsp_seen) begin
      s_d.rsp_seen = rsp_tgl_s;
      s_d.ack_tgl = rsp_tgl_s;
      s_d.rsp_write = m_q.rsp.write;
      s_d.rsp_addr = m_q.rsp.addr;
      s_d.rsp_data = m_q.rsp.data;
      if (m_q.rsp.boot) begin
        s_d.boot_valid = 1'b1;
        if (m_q.rsp.addr == eesm_pkg::LAST_ADDR) begin
          s_d.boot_done = 1'b1;
        end
      end else begin
        s_d.rsp_valid = 1'b1;
        s_d.busy = 1'b0;
      end
    end
    s_d.ready = s_d.boot_done && !s_d.busy;
  end

  // System-side register
  always_ff @(posedge sys_clk_i or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------- Link-side logic ----------------
  // Load one command into the engine and move on
  function automatic eesm_mem_t issue(input eesm_mem_t s, input eesm_mstate_t nst,
      input logic [1:0] op, input logic [eesm_pkg::ADDR_W-1:0] a,
      input logic [eesm_pkg::DATA_W-1:0] d, input logic [4:0] len, input logic [3:0] rxl);
    eesm_mem_t r;
    r = s;
    r.st = nst;
    r.start = 1'b1;
    r.poll = 1'b0;
    r.tx = eesm_pkg::eesm_frame_f(op, a, d);
    r.tx_len = len;
    r.rx_len = rxl;
    return r;
  endfunction : issue

  always_comb begin
    m_d = m_q;
    m_d.start = 1'b0;
    unique case (m_q.st)
      M_BOOT: begin
        // Power-on read of the next word
        m_d = issue(m_q, M_BOOT_WT, eesm_pkg::OP_READ, m_q.boot_addr, '0,
                    eesm_pkg::LEN_CMD, eesm_pkg::RX_BYTE);
      end
      M_BOOT_WT: begin
        if (eng_done) begin
          m_d.pend = '{boot: 1'b1, write: 1'b0, addr: m_q.boot_addr, data: eng_rx};
          m_d.st = M_POST;
        end
      end
      M_POST: begin
        // Post only once the previous result was consumed
        if (ack_tgl_m == m_q.rsp_tgl) begin
          m_d.rsp = m_q.pend;
          m_d.rsp_tgl = ~m_q.rsp_tgl;
          if (m_q.pend.boot && m_q.boot_addr != eesm_pkg::LAST_ADDR) begin
            m_d.boot_addr = m_q.boot_addr + 7'h01;
            m_d.st = M_BOOT;
          end else begin
            m_d.st = M_IDLE;
          end
        end
      end
      M_IDLE: begin
        if (req_tgl_m != m_q.req_seen) begin
          m_d.req_seen = req_tgl_m;
          m_d.req = s_q.req; // Held stable by the system side
          if (s_q.req.write) begin
            m_d = issue(m_d, M_UNLOCK, eesm_pkg::OP_EXT, eesm_pkg::EXT_UNLOCK, '0,
                        eesm_pkg::LEN_CMD, eesm_pkg::RX_NONE);
          end else begin
            m_d = issue(m_d, M_READ, eesm_pkg::OP_READ, s_q.req.addr, '0,
                        eesm_pkg::LEN_CMD, eesm_pkg::RX_BYTE);
          end
        end
      end
      M_UNLOCK: begin
        if (eng_done) begin
          m_d = issue(m_q, M_WRITE, eesm_pkg::OP_WRITE, m_q.req.addr, m_q.req.wdata,
                      eesm_pkg::LEN_WRITE, eesm_pkg::RX_NONE);
        end
      end
      M_WRITE: begin
        if (eng_done) begin
          // Reselect and watch the line for write completion
          m_d = issue(m_q, M_POLL, eesm_pkg::OP_EXT, '0, '0, 5'h00,
                      eesm_pkg::RX_NONE);
          m_d.poll = 1'b1;
        end
      end
      M_POLL: begin
        if (eng_done) begin
          m_d = issue(m_q, M_LOCK, eesm_pkg::OP_EXT, eesm_pkg::EXT_LOCK, '0,
                      eesm_pkg::LEN_CMD, eesm_pkg::RX_NONE);
        end
      end
      M_LOCK: begin
        if (eng_done) begin
          m_d.pend = '{boot: 1'b0, write: 1'b1, addr: m_q.req.addr, data: m_q.req.wdata};
          m_d.st = M_POST;
        end
      end
      M_READ: begin
        if (eng_done) begin
          m_d.pend = '{boot: 1'b0, write: 1'b0, addr: m_q.req.addr, data: eng_rx};
          m_d.st = M_POST;
        end
      end
      default: m_d.st = M_IDLE;
    endcase
  end

  // Link-side register
  always_ff @(posedge mem_clk_i or negedge mem_rst_n) begin
    if (!mem_rst_n) begin
      m_q <= '0;
    end else begin
      m_q <= m_d;
    end
  end

  // Serial engine on the memory clock
  eesm_frame u_frame (
    .clk_i(mem_clk_i),
    .rst_n_i(mem_rst_n),
    .start_i(m_q.start),
    .poll_i(m_q.poll),
    .tx_i(m_q.tx),
    .tx_len_i(m_q.tx_len),
    .rx_len_i(m_q.rx_len),
    .din_i(din_m),
    .done_o(eng_done),
    .rx_o(eng_rx),
    .sel_o(eeprom_select_o),
    .sck_o(eeprom_serial_clock_o),
    .dout_o(eeprom_serial_data_o),
    .doe_o(eeprom_serial_data_oe_o)
  );

  // User-side outputs from system-side flops
  assign req_ready_o = s_q.ready;
  assign rsp_valid_o = s_q.rsp_valid;
  assign rsp_write_o = s_q.rsp_write;
  assign rsp_addr_o = s_q.rsp_addr;
  assign rsp_data_o = s_q.rsp_data;
  assign boot_valid_o = s_q.boot_valid;
  assign boot_done_o = s_q.boot_done;
endmodule : eesm_top

// *** eesm_top_asserts.sv ***
// Purpose: Link timing checks of the serial EEPROM master
// Assumes: All checks run on the memory clock
// Notes: Helper counters saturate at 8'hff, read as a long time
`timescale 1ns/1ps
module eesm_top_asserts (
  input wire logic mem_clk_i,
  input wire logic rst_n_i,
  input wire logic eeprom_select_o,
  input wire logic eeprom_serial_clock_o,
  input wire logic eeprom_serial_data_o,
  input wire logic eeprom_serial_data_oe_o,
  input wire logic eeprom_serial_data_i
);
  default clocking cb @(posedge mem_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic sck_q; // Clock one sample ago
  logic dat_q; // Data one sample ago
  logic oe_q; // Enable one sample ago
  logic [7:0] run_q; // Length of the current clock phase
  logic [7:0] hi_q; // Length of the last high phase
  logic [7:0] sel_run_q; // Samples since select rose
  logic [7:0] dat_run_q; // Driven bit age
  logic [7:0] rise_q; // Samples since the last clock rise
  logic [7:0] nrise_q; // Rises in this select
  // Saturating step
  function automatic logic [7:0] inc(input logic [7:0] v);
    return (v == 8'hff) ? v : v + 8'h01;
  endfunction : inc
  // Helper counters
  always_ff @(posedge mem_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_q <= 1'b0;
      dat_q <= 1'b0;
      oe_q <= 1'b0;
      run_q <= 8'h00;
      hi_q <= 8'hff;
      sel_run_q <= 8'h00;
      dat_run_q <= 8'h00;
      rise_q <= 8'hff;
      nrise_q <= 8'h00;
    end else begin
      sck_q <= eeprom_serial_clock_o;
      dat_q <= eeprom_serial_data_o;
      oe_q <= eeprom_serial_data_oe_o;
      run_q <= (eeprom_serial_clock_o != sck_q) ? 8'h01 : inc(run_q);
      // High length at fall
      if (!eeprom_serial_clock_o && sck_q) begin
        hi_q <= run_q;
      end
      sel_run_q <= eeprom_select_o ? inc(sel_run_q) : 8'h00;
      dat_run_q <= ({eeprom_serial_data_oe_o, eeprom_serial_data_o} != {oe_q, dat_q}) ?
                   8'h01 : inc(dat_run_q);
      rise_q <= (eeprom_serial_clock_o && !sck_q) ? 8'h01 : inc(rise_q);
      // Rises per selection
      if (!eeprom_select_o) begin
        nrise_q <= 8'h00;
      end else if (eeprom_serial_clock_o && !sck_q) begin
        nrise_q <= inc(nrise_q);
      end
    end
  end
  property p_low; $rose(eeprom_serial_clock_o) |-> run_q >= 8'h18; endproperty
  a_low: assert property (p_low) else $error("clock low phase too short");
  property p_high; $fell(eeprom_serial_clock_o) |-> run_q >= 8'h18; endproperty
  a_high: assert property (p_high) else $error("clock high phase too short");
  property p_period; $rose(eeprom_serial_clock_o) |-> ({1'b0, run_q} + {1'b0, hi_q}) >= 9'h032;
  endproperty
  a_period: assert property (p_period) else $error("clock period too short");
  property p_rate; $rose(eeprom_serial_clock_o) |-> ({1'b0, run_q} + {1'b0, hi_q}) > 9'h021;
  endproperty
  a_rate: assert property (p_rate) else $error("bit rate too high");
  property p_lead; $rose(eeprom_serial_clock_o) |-> eeprom_select_o && sel_run_q >= 8'h0f;
  endproperty
  a_lead: assert property (p_lead) else $error("select lead too short");
  property p_setup; $rose(eeprom_serial_clock_o) && eeprom_serial_data_oe_o |->
    $stable(eeprom_serial_data_o) && dat_run_q >= 8'h0f; endproperty
  a_setup: assert property (p_setup) else $error("data setup too short");
  property p_hold; (eeprom_serial_data_oe_o && $changed(eeprom_serial_data_o)) ||
    $fell(eeprom_serial_data_oe_o) |-> rise_q >= 8'h0f; endproperty
  a_hold: assert property (p_hold) else $error("data hold too short");
  property p_start; $rose(eeprom_serial_clock_o) && nrise_q == 8'h00 |->
    eeprom_serial_data_oe_o && eeprom_serial_data_o; endproperty
  a_start: assert property (p_start) else $error("frame lacks start bit");
  property p_poll; $fell(eeprom_select_o) && nrise_q == 8'h00 |-> $past(eeprom_serial_data_i, 2);
  endproperty
  a_poll: assert property (p_poll) else $error("poll ended before ready");
endmodule : eesm_top_asserts

bind eesm_top eesm_top_asserts u_asserts (.mem_clk_i(mem_clk_i), .rst_n_i(rst_n_i),
  .eeprom_select_o(eeprom_select_o), .eeprom_serial_clock_o(eeprom_serial_clock_o),
  .eeprom_serial_data_o(eeprom_serial_data_o), .eeprom_serial_data_oe_o(eeprom_serial_data_oe_o),
  .eeprom_serial_data_i(eeprom_serial_data_i));

// *** eesm_top_tb.sv ***
// Purpose: Self-checking bench of the serial EEPROM master
// Assumes: Data line has a pull-down; memory model starts locked
// Notes: Power-on read of all words dominates the run time
`timescale 1ns/1ps
module eesm_top_tb;
  logic sys_clk_i, mem_clk_i, rst_n_i; // Clocks and reset
  logic req_valid_i, req_write_i; // Request strobe and kind
  logic [eesm_pkg::ADDR_W-1:0] req_addr_i, rsp_addr_o; // Addresses
  logic [eesm_pkg::DATA_W-1:0] req_wdata_i, rsp_data_o; // Data
  logic req_ready_o, rsp_valid_o, rsp_write_o, boot_valid_o, boot_done_o; // Status
  logic sel, sck, sd_o, sd_oe, mem_d, mem_oe, sd_line; // Link wires
  logic [15:0] busy_i; // Model write busy time
  logic [7:0] exp_mem [0:127]; // Expected contents
  int fail_count, n_tests, boot_idx, collide; // Counters
  // Clocks of unrelated phase
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    mem_clk_i = 1'b0;
    #7;
    forever #15 mem_clk_i = ~mem_clk_i;
  end
  // Line level, pull-down when released
  assign sd_line = sd_oe ? sd_o : (mem_oe ? mem_d : 1'b0);
  eesm_top uut (.sys_clk_i(sys_clk_i), .mem_clk_i(mem_clk_i), .rst_n_i(rst_n_i),
    .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_write_o(rsp_write_o), .rsp_addr_o(rsp_addr_o), .rsp_data_o(rsp_data_o),
    .boot_valid_o(boot_valid_o), .boot_done_o(boot_done_o), .eeprom_select_o(sel),
    .eeprom_serial_clock_o(sck), .eeprom_serial_data_o(sd_o),
    .eeprom_serial_data_oe_o(sd_oe), .eeprom_serial_data_i(sd_line));
  eesm_eeprom_model u_mem (.sel_i(sel), .sck_i(sck), .din_i(sd_line), .busy_i(busy_i),
    .dout_o(mem_d), .doe_o(mem_oe));
  // Compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Verdict and stop
  task automatic end_sim();
    $display("counts: tests=%0d fails=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // Contention
  always @(posedge mem_clk_i) if (sd_oe === 1'b1 && mem_oe === 1'b1) collide++;
  // Power-on words in order
  always @(negedge sys_clk_i) if (boot_valid_o === 1'b1) begin
    check(16'(rsp_addr_o), 16'(boot_idx));
    check(16'(rsp_data_o), 16'(exp_mem[boot_idx[6:0]]));
    check(16'(req_ready_o), 16'(boot_idx == 127));
    boot_idx++;
  end
  // One request, then its result
  task automatic do_req(input logic wr, input logic [6:0] a, input logic [7:0] d,
                        output logic [7:0] rd, output time t_take);
    int n;
    @(negedge sys_clk_i);
    {req_valid_i, req_write_i, req_addr_i, req_wdata_i} = {1'b1, wr, a, d};
    for (n = 0; req_ready_o !== 1'b1 && n < 20000; n++) @(negedge sys_clk_i);
    @(posedge sys_clk_i);
    t_take = $time;
    @(negedge sys_clk_i);
    req_valid_i = 1'b0;
    for (n = 0; rsp_valid_o !== 1'b1 && n < 60000; n++) @(negedge sys_clk_i);
    check(16'(rsp_valid_o), 16'h0001);
    check(16'({rsp_write_o, rsp_addr_o}), 16'({wr, a}));
    rd = rsp_data_o;
  endtask : do_req
  // Read one word
  task automatic t_read(input logic [6:0] a);
    logic [7:0] rd;
    time t;
    do_req(1'b0, a, 8'h00, rd, t);
    check(16'(rd), 16'(exp_mem[a]));
  endtask : t_read
  // Write with a given busy time
  task automatic t_write(input logic [6:0] a, input logic [7:0] d, input logic [15:0] bz);
    logic [7:0] rd;
    time t;
    busy_i = bz;
    do_req(1'b1, a, d, rd, t);
    check(16'(rd), 16'(d));
    check(16'(($time - t) >= bz * 100), 16'h0001);
    check(16'(u_mem.busy), 16'h0000);
    check(16'(u_mem.hist), 16'h0123);
    check(16'(u_mem.locked), 16'h0001);
    check(16'(u_mem.mem[a]), 16'(d));
    exp_mem[a] = d;
  endtask : t_write
  // Whole power-on read
  task automatic t_boot();
    int n;
    for (n = 0; boot_done_o !== 1'b1 && n < 700000; n++) @(negedge sys_clk_i);
    @(posedge sys_clk_i);
    check(16'(boot_done_o), 16'h0001);
    check(16'(boot_idx), 16'h0080);
  endtask : t_boot
  // First and last word
  task automatic t_edges();
    t_read(7'h7f);
    t_read(7'h00);
  endtask : t_edges
  // Slow and prompt write, read back
  task automatic t_writes();
    t_write(7'h05, 8'h3c, 16'd200);
    t_write(7'h7f, 8'hc3, 16'd0);
    t_read(7'h05);
    t_read(7'h7f);
  endtask : t_writes
  // Watchdog
  initial begin
    #10_000_000;
    fail_count++;
    end_sim();
  end
  // Main sequence
  initial begin
    for (int i = 0; i < 128; i++) begin
      exp_mem[i] = {i[6:0], 1'b0} ^ 8'ha5;
    end
    {req_valid_i, req_write_i, req_addr_i, req_wdata_i} = '0;
    {fail_count, n_tests, boot_idx, collide} = '0;
    busy_i = 16'h0000;
    rst_n_i = 1'b0;
    repeat (2) @(posedge mem_clk_i);
    @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    t_boot();
    t_edges();
    t_writes();
    check(16'(collide), 16'h0000);
    end_sim();
  end
endmodule : eesm_top_tb
